/* File: verilog/ulpi_phy_end.sv */
// Transceiver end of the ULPI pin interface: direction, throttle, reset handling.
// Assumes the link end keeps its bus release and stop timing.
`timescale 1ns/100ps
module ulpi_phy_end
    import ulpi_pkg::*;
(
    input  wire logic                    clk_sys,     // System clock.
    input  wire logic                    rst_n,       // Power-on reset.
    ulpi_if.phy                          ulpi,        // Pins to the link.
    input  wire logic [ulpi_pkg::DATA_W-1:0] rx_data, // Bytes for the link.
    input  wire logic                    rx_valid,    // Byte available.
    output logic                         rx_ready,    // Buffer not full; a byte is taken only while active.
    output logic [ulpi_pkg::DATA_W-1:0]  tx_data,     // Byte received from link.
    output logic                         tx_valid,    // One-cycle byte strobe.
    output logic                         tx_last,     // Stream ended by stop.
    input  wire logic                    tx_ready,    // Consumer can take a byte.
    output logic                         chip_held    // Reset hold time met.
);
    import ulpi_pkg::*;

    phy_state_t           state_ff;
    logic                 rst_meta_ff;
    logic                 rst_sync_ff;
    logic                 drive_ff;
    logic [RST_CNT_W-1:0] hold_cnt_ff;
    logic                 held_ff;
    logic                 run_ff;
    logic                 div_ff;
    logic [7:0]           dout_ff;
    logic                 dir_ff;
    logic                 nxt_ff;
    logic                 oe_n_ff;
    logic [7:0]           tx_data_ff;
    logic                 tx_valid_ff;
    logic                 tx_last_ff;
    logic                 sw_ff;
    logic [7:0]           buf_data;
    logic                 buf_valid;
    logic                 buf_pop;
    logic                 active;

    // Receive buffer between the user source and the bus.
    sync_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo
    (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .in_data   (rx_data),
        .in_valid  (rx_valid && active),
        .in_ready  (rx_ready),
        .out_data  (buf_data),
        .out_valid (buf_valid),
        .out_ready (buf_pop)
    );

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= ulpi.chip_reset_active_low;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hold_cnt_ff <= '0;
            held_ff     <= 1'b0;
            run_ff      <= 1'b0;
        end
        else if (!rst_sync_ff)
        begin
            run_ff <= 1'b0;
            if (hold_cnt_ff != RST_CNT_W'(RST_HOLD_CYC))
            begin
                hold_cnt_ff <= hold_cnt_ff + 1'b1;
            end
            else
            begin
                held_ff <= 1'b1;
            end
        end
        else
        begin
            // A short pulse only suspends; a full one also sets the held flag.
            hold_cnt_ff <= '0;
            run_ff      <= 1'b1;
        end
    end

    assign active  = run_ff && rst_sync_ff;
    assign buf_pop = active && (state_ff == PHY_RX) && buf_valid;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_ff <= 1'b0;
        end
        else
        begin
            div_ff <= active ? ~div_ff : 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= PHY_IDLE;
            dir_ff   <= 1'b0;
            dout_ff  <= DATA_RESET;
        end
        else if (!active)
        begin
            state_ff <= PHY_IDLE;
            dir_ff   <= 1'b0;
            dout_ff  <= DATA_RESET;
        end
        else
        begin
            case (state_ff)
                PHY_IDLE:
                begin
                    if (buf_valid && ulpi.data_i == CMD_IDLE)
                    begin
                        state_ff <= PHY_RX;
                        dir_ff   <= 1'b1;
                    end
                    else if (ulpi.data_i != CMD_IDLE)
                    begin
                        state_ff <= PHY_TX;
                    end
                end
                PHY_RX:
                begin
                    // Whole byte, bit 7 most significant.
                    dout_ff <= buf_data;
                    if (!buf_valid)
                    begin
                        state_ff <= PHY_IDLE;
                        dir_ff   <= 1'b0;
                    end
                end
                PHY_TX:
                begin
                    if (ulpi.stp)
                    begin
                        state_ff <= PHY_IDLE;
                    end
                end
                default:
                begin
                    state_ff <= PHY_IDLE;
                end
            endcase
        end
    end

    // Turnaround cycle after direction.
    // The link releases the bus on the first edge that samples direction high, so
    // driving data only from the following cycle keeps the two drivers apart.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            drive_ff <= 1'b0;
        end
        else
        begin
            drive_ff <= active && dir_ff;
        end
    end

    // Throttle and capture.
    // Stop is launched on this same clock, so it is read without a synchroniser.
    // The byte slot that carries the stop is never taken.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            nxt_ff      <= 1'b0;
            tx_data_ff  <= DATA_RESET;
            tx_valid_ff <= 1'b0;
            tx_last_ff  <= 1'b0;
        end
        else
        begin
            nxt_ff      <= active && (state_ff == PHY_TX) && tx_ready && !ulpi.stp;
            tx_valid_ff <= active && nxt_ff && !ulpi.stp;
            tx_last_ff  <= active && (state_ff == PHY_TX) && ulpi.stp;
            if (nxt_ff && !ulpi.stp)
            begin
                tx_data_ff <= ulpi.data_i;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            oe_n_ff <= 1'b1;
        end
        else
        begin
            oe_n_ff <= !active;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sw_ff <= 1'b1;
        end
        else
        begin
            sw_ff <= !rst_sync_ff;
        end
    end

    assign ulpi.data_phy_o             = dout_ff;
    assign ulpi.data_phy_oe_n          = oe_n_ff || !dir_ff || !drive_ff;
    assign ulpi.dir                    = dir_ff;
    assign ulpi.dir_oe_n               = oe_n_ff;
    assign ulpi.nxt                    = nxt_ff;
    assign ulpi.nxt_oe_n               = oe_n_ff;
    assign ulpi.clk_en                 = div_ff;
    assign ulpi.interface_clock_output = div_ff;
    assign ulpi.switch_closed          = sw_ff;
    assign tx_data                     = tx_data_ff;
    assign tx_valid                    = tx_valid_ff;
    assign tx_last                     = tx_last_ff;
    assign chip_held                   = held_ff;
endmodule : ulpi_phy_end

/* File: verilog/ulpi_pkg.sv */
// Package of shared constants and types for the ULPI pin-level link.
// Assumes a single 50 MHz system clock drives both ends in simulation.
package ulpi_pkg;
    localparam int unsigned DATA_W          = 8;
    localparam int unsigned FIFO_DEPTH      = 32;
    localparam int unsigned CLK_PERIOD_NS   = 20;
    // Least reset hold, in nanoseconds.
    localparam int unsigned RST_HOLD_NS     = 1000;
    localparam int unsigned RST_HOLD_CYC    = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RST_CNT_W       = 6;
    // Interface clock divider: one enable pulse every CLK_DIV cycles.
    localparam int unsigned CLK_DIV         = 2;
    localparam logic [7:0]  DATA_RESET      = 8'h00;
    localparam logic [7:0]  CMD_IDLE        = 8'h00;

    typedef enum logic [1:0]
    {
        PHY_IDLE = 2'b00,
        PHY_RX   = 2'b01,
        PHY_TX   = 2'b10
    } phy_state_t;

    typedef enum logic [1:0]
    {
        LNK_IDLE = 2'b00,
        LNK_SEND = 2'b01,
        LNK_STOP = 2'b10
    } link_state_t;
endpackage : ulpi_pkg

/* File: verilog/ulpi_if.sv */
// Interface carrying the ULPI pins between the transceiver end and the link end.
// The interface resolves the shared data bus from the two output enables, transceiver first.
`timescale 1ns/100ps
interface ulpi_if;
    logic [7:0] data_phy_o;   // Data driven by the transceiver.
    logic       data_phy_oe_n; // Transceiver data enable, low drives.
    logic [7:0] data_lnk_o;   // Data driven by the link.
    logic       data_lnk_oe_n; // Link data enable, low drives.
    logic [7:0] data_i;       // Resolved bus level.
    logic       dir;          // Bus direction, high when transceiver owns it.
    logic       dir_oe_n;     // Direction pin enable, low drives.
    logic       nxt;          // Byte accepted or next byte valid.
    logic       nxt_oe_n;     // Throttle pin enable, low drives.
    logic       stp;          // One-cycle stop from the link.
    logic       chip_reset_active_low; // Chip reset pin from the board.
    logic       clk_en;       // Interface clock enable from the transceiver.
    logic       interface_clock_output; // Interface clock pin level.
    logic       switch_closed; // Audio switch state.

    assign data_i = !data_phy_oe_n ? data_phy_o : (!data_lnk_oe_n ? data_lnk_o : 8'h00);

    modport phy
    (
        output data_phy_o, data_phy_oe_n, dir, dir_oe_n, nxt, nxt_oe_n,
        output clk_en, interface_clock_output, switch_closed,
        input  data_i, stp, chip_reset_active_low
    );
    modport link
    (
        output data_lnk_o, data_lnk_oe_n, stp,
        input  data_i, dir, nxt, clk_en, dir_oe_n
    );
endinterface : ulpi_if

/* File: verilog/sync_fifo.sv */
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/100ps
module sync_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 32
) (
    input  wire logic             clk_sys,  // System clock.
    input  wire logic             rst_n,    // Asynchronous reset.
    input  wire logic [WIDTH-1:0] in_data,  // Write data.
    input  wire logic             in_valid, // Write request.
    output logic                  in_ready, // Not full.
    output logic [WIDTH-1:0]      out_data, // Head entry.
    output logic                  out_valid, // Not empty.
    input  wire logic             out_ready  // Read accept.
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ff;
    logic [AW-1:0]    rd_ff;
    logic [AW:0]      cnt_ff;
    logic             push;
    logic             pop;

    // Full and empty come from the occupancy count.
    assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign out_data  = mem_ff[rd_ff];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Storage write; no reset needed on data.
    always_ff @(posedge clk_sys)
    begin
        if (push)
        begin
            mem_ff[wr_ff] <= in_data;
        end
    end

    // Pointers and count.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ff <= wr_ff + 1'b1;
            end
            if (pop)
            begin
                rd_ff <= rd_ff + 1'b1;
            end
            if (push && !pop)
            begin
                cnt_ff <= cnt_ff + 1'b1;
            end
            else if (pop && !push)
            begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end
    end
endmodule : sync_fifo

/* File: verilog/ulpi_link_end.sv */
// Link end of the ULPI pin interface: sends byte streams, ends them with a stop.
// Assumes the transceiver end owns direction and throttle.
`timescale 1ns/100ps
module ulpi_link_end
    import ulpi_pkg::*;
(
    input  wire logic                        clk_sys,  // System clock.
    input  wire logic                        rst_n,    // Asynchronous reset.
    ulpi_if.link                             ulpi,     // Pins to the transceiver.
    input  wire logic [ulpi_pkg::DATA_W-1:0] send_data, // Byte to send, nonzero first.
    input  wire logic                        send_valid, // Byte offered.
    input  wire logic                        send_last,  // Final byte of stream.
    output logic                             send_ready, // Byte taken.
    output logic [ulpi_pkg::DATA_W-1:0]      recv_data,  // Byte from transceiver.
    output logic                             recv_valid  // One-cycle strobe.
);
    import ulpi_pkg::*;

    link_state_t state_ff;
    logic [7:0]  dout_ff;
    logic        oe_n_ff;
    logic        stp_ff;
    logic        last_ff;
    logic [7:0]  recv_ff;
    logic        recv_v_ff;
    logic        dir_q_ff;

    assign send_ready = (state_ff == LNK_IDLE && !ulpi.dir && send_valid) ||
                        (state_ff == LNK_SEND && ulpi.nxt && !last_ff);

    // Stream sender; bus released from the edge after direction goes high.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= LNK_IDLE;
            dout_ff  <= CMD_IDLE;
            oe_n_ff  <= 1'b0;
            stp_ff   <= 1'b0;
            last_ff  <= 1'b0;
        end
        else
        begin
            stp_ff <= 1'b0;
            case (state_ff)
                LNK_IDLE:
                begin
                    oe_n_ff <= ulpi.dir;
                    dout_ff <= CMD_IDLE;
                    if (!ulpi.dir && send_valid)
                    begin
                        dout_ff  <= send_data;
                        last_ff  <= send_last;
                        state_ff <= LNK_SEND;
                    end
                end
                LNK_SEND:
                begin
                    if (ulpi.nxt)
                    begin
                        if (last_ff)
                        begin
                            dout_ff  <= CMD_IDLE;
                            stp_ff   <= 1'b1;
                            state_ff <= LNK_STOP;
                        end
                        else
                        begin
                            dout_ff <= send_data;
                            last_ff <= send_last;
                        end
                    end
                end
                LNK_STOP:
                begin
                    state_ff <= LNK_IDLE;
                end
                default:
                begin
                    state_ff <= LNK_IDLE;
                end
            endcase
            if (ulpi.dir)
            begin
                oe_n_ff <= 1'b1;
            end
        end
    end

    // Receive path; first cycle after turnaround is skipped.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dir_q_ff  <= 1'b0;
            recv_ff   <= 8'h00;
            recv_v_ff <= 1'b0;
        end
        else
        begin
            dir_q_ff  <= ulpi.dir && !ulpi.dir_oe_n;
            recv_v_ff <= dir_q_ff && ulpi.dir;
            recv_ff   <= ulpi.data_i;
        end
    end

    assign ulpi.data_lnk_o    = dout_ff;
    assign ulpi.data_lnk_oe_n = oe_n_ff;
    assign ulpi.stp           = stp_ff;
    assign recv_data          = recv_ff;
    assign recv_valid         = recv_v_ff;
endmodule : ulpi_link_end

/* File: bench/ulpi_sva.sv */
// Checker for the ULPI pins between the transceiver end and the link end.
// Assumes the testbench wires it beside the interface instance, one clock domain.
`timescale 1ns/100ps
module ulpi_sva
(
    input wire logic clk_sys,                // System clock.
    input wire logic rst_n,                  // Asynchronous reset.
    input wire logic data_phy_oe_n,          // Transceiver data enable.
    input wire logic data_lnk_oe_n,          // Link data enable.
    input wire logic dir,                    // Bus direction.
    input wire logic dir_oe_n,               // Direction enable.
    input wire logic nxt,                    // Throttle.
    input wire logic nxt_oe_n,               // Throttle enable.
    input wire logic stp,                    // Stop from the link.
    input wire logic chip_reset_active_low,  // Chip reset pin.
    input wire logic switch_closed,          // Audio switch state.
    input wire logic interface_clock_output  // Interface clock pin.
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // Two drivers on the shared bus would corrupt every byte.
    property p_no_clash;
        !(!data_phy_oe_n && !data_lnk_oe_n);
    endproperty
    a_no_clash: assert property (p_no_clash) else $error("both ends drive data");

    // Two edges fill the synchroniser and a third registers the enables, so the
    // pins float from the fourth low sample on.
    property p_rst_float;
        !chip_reset_active_low [*4] |-> data_phy_oe_n && dir_oe_n && nxt_oe_n;
    endproperty
    a_rst_float: assert property (p_rst_float) else $error("pins driven in chip reset");

    property p_rst_switch;
        !chip_reset_active_low [*4] |-> switch_closed;
    endproperty
    a_rst_switch: assert property (p_rst_switch) else $error("switch open in chip reset");

    property p_stp_one;
        $rose(stp) |=> !stp;
    endproperty
    a_stp_one: assert property (p_stp_one) else $error("stop longer than one cycle");

    property p_stp_dir;
        stp |-> !dir;
    endproperty
    a_stp_dir: assert property (p_stp_dir) else $error("stop while direction high");

    property p_dir_release;
        dir [*2] |-> data_lnk_oe_n;
    endproperty
    a_dir_release: assert property (p_dir_release) else $error("link drives under dir");

    property p_nxt_dir;
        nxt && !nxt_oe_n |-> !dir;
    endproperty
    a_nxt_dir: assert property (p_nxt_dir) else $error("throttle while phy owns bus");

    // The divided clock must keep moving while the chip runs.
    property p_clk_runs;
        chip_reset_active_low [*8] |-> ##[0:2] $changed(interface_clock_output);
    endproperty
    a_clk_runs: assert property (p_clk_runs) else $error("interface clock stalled");
endmodule : ulpi_sva

/* File: bench/testbench.sv */
// Self-checking bench: both ULPI ends joined through one interface.
// Assumes the package constants and the hand-over latencies of the two ends.
`timescale 1ns/100ps
module testbench;
    import ulpi_pkg::*;
    logic       clk_sys, rst_n, chip_reset_active_low;
    logic [7:0] rx_data, tx_data, send_data, recv_data;
    logic       rx_valid, rx_ready, tx_valid, tx_last, tx_ready, chip_held;
    logic       send_valid, send_last, send_ready, recv_valid, dir_seen;
    logic [7:0] tx_q[$], rx_q[$];
    int         n_errors, compares, n_stp, n_nxt, n_last;

    ulpi_if u();
    assign u.chip_reset_active_low = chip_reset_active_low;
    ulpi_phy_end ulpi_phy_end_i (.clk_sys(clk_sys), .rst_n(rst_n), .ulpi(u.phy),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready), .chip_held(chip_held));
    ulpi_link_end ulpi_link_end_i (.clk_sys(clk_sys), .rst_n(rst_n), .ulpi(u.link),
        .send_data(send_data), .send_valid(send_valid), .send_last(send_last),
        .send_ready(send_ready), .recv_data(recv_data), .recv_valid(recv_valid));
    ulpi_sva ulpi_sva_i (.clk_sys(clk_sys), .rst_n(rst_n), .data_phy_oe_n(u.data_phy_oe_n),
        .data_lnk_oe_n(u.data_lnk_oe_n), .dir(u.dir), .dir_oe_n(u.dir_oe_n), .nxt(u.nxt),
        .nxt_oe_n(u.nxt_oe_n), .stp(u.stp), .chip_reset_active_low(u.chip_reset_active_low),
        .switch_closed(u.switch_closed), .interface_clock_output(u.interface_clock_output));

    // Bench supplies the clock.
    // Free-running 50 MHz clock; both ends run on it, as in clock-in operation.
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // Records strobes and wire events before this edge's updates land.
    always @(posedge clk_sys)
    begin
        if (tx_valid === 1'b1) tx_q.push_back(tx_data);
        if (recv_valid === 1'b1) rx_q.push_back(recv_data);
        if (u.stp === 1'b1) n_stp++;
        // A stop cycle carries no byte, so throttle high there is no acceptance.
        if (u.nxt === 1'b1 && u.nxt_oe_n === 1'b0 && u.stp !== 1'b1) n_nxt++;
        if (tx_last === 1'b1) n_last++;
        if (u.dir === 1'b1 && u.dir_oe_n === 1'b0) dir_seen = 1'b1;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict;
        $display("errors=%0d compares=%0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    // A short pulse suspends only; a long one must also set the hold flag.
    task automatic t_chip_reset;
        @(negedge clk_sys) chip_reset_active_low = 1'b0;
        repeat (10) @(negedge clk_sys);
        check({7'h00, u.switch_closed}, 8'h01);
        check({5'h00, u.data_phy_oe_n, u.dir_oe_n, u.nxt_oe_n}, 8'h07);
        chip_reset_active_low = 1'b1;
        repeat (10) @(negedge clk_sys);
        check({7'h00, chip_held}, 8'h00);
        chip_reset_active_low = 1'b0;
        repeat (RST_HOLD_CYC + 10) @(negedge clk_sys);
        chip_reset_active_low = 1'b1;
        repeat (10) @(negedge clk_sys);
        check({7'h00, chip_held}, 8'h01);
        check({6'h00, u.switch_closed, u.dir_oe_n}, 8'h00);
    endtask : t_chip_reset

    // Link stream against a stalled consumer, then released.
    task automatic t_link_stream(input logic [7:0] b0, input logic [7:0] b1);
        logic [7:0] exp[4];
        exp = '{b0, b1, 8'h81, 8'h7E};
        tx_q.delete();
        n_stp = 0;
        n_nxt = 0;
        n_last = 0;
        tx_ready = 1'b0;
        fork
            for (int k = 0; k < 4; k++)
            begin
                @(negedge clk_sys);
                send_data = exp[k];
                send_valid = 1'b1;
                send_last = (k == 3);
                #1;
                for (int w = 0; w < 300 && send_ready !== 1'b1; w++) @(negedge clk_sys);
            end
            begin
                repeat (12) @(negedge clk_sys);
                check(8'(tx_q.size()), 8'h00);
                tx_ready = 1'b1;
            end
        join
        @(negedge clk_sys) send_valid = 1'b0;
        send_last = 1'b0;
        repeat (30) @(negedge clk_sys);
        check(8'(tx_q.size()), 8'h04);
        foreach (exp[k]) check(tx_q.size() > k ? tx_q[k] : 8'hXX, exp[k]);
        check(8'(n_nxt), 8'h04);
        check(8'(n_stp), 8'h01);
        check(8'(n_last), 8'h01);
    endtask : t_link_stream

    // Forty bytes from the transceiver must reach the link in order.
    task automatic t_phy_stream;
        rx_q.delete();
        dir_seen = 1'b0;
        for (int k = 0; k < 40; k++)
        begin
            @(negedge clk_sys);
            rx_data = 8'(k * 7 + 17);
            rx_valid = 1'b1;
            #1;
            for (int w = 0; w < 300 && rx_ready !== 1'b1; w++) @(negedge clk_sys);
        end
        @(negedge clk_sys) rx_valid = 1'b0;
        repeat (150) @(negedge clk_sys);
        check({7'h00, dir_seen}, 8'h01);
        check({7'h00, u.dir}, 8'h00);
        check(8'(rx_q.size()), 8'h28);
        for (int k = 0; k < 40; k++)
            check(rx_q.size() > k ? rx_q[k] : 8'hXX, 8'(k * 7 + 17));
    endtask : t_phy_stream

    // Cuts a hang short well beyond the expected run length.
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        print_verdict();
    end

    // Main sequence: reset, then the scenarios back to back.
    initial
    begin
        n_errors = 0;
        compares = 0;
        rst_n = 1'b0;
        chip_reset_active_low = 1'b1;
        {rx_data, rx_valid, tx_ready, send_data, send_valid, send_last} = '0;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys) rst_n = 1'b1;
        repeat (10) @(negedge clk_sys);
        t_chip_reset();
        t_link_stream(8'hA5, 8'h3C);
        t_phy_stream();
        t_link_stream(8'h41, 8'hFF);
        print_verdict();
    end
endmodule : testbench
